// >>> rtl/bcp_defs.svh
// Constants of the position link: frame layout, levels and timing counts.
// Assumes a 40 MHz core clock; included by the package and by both ends.
`ifndef BCP_DEFS_SVH
`define BCP_DEFS_SVH

`define BCP_RES_DEF      17
`define BCP_RES_MIN      17
`define BCP_RES_MAX      20
// Frame indices count down to zero; the ack sits this far above the resolution
`define BCP_ACK_OFS      10
`define BCP_START_OFS    9
`define BCP_ZERO_OFS     8
`define BCP_POS_LSB      8
`define BCP_ERR_POS      7
`define BCP_WARN_POS     6
`define BCP_CRC_W        6
`define BCP_CRC_POLY     6'h03
`define BCP_ACK_LVL      1'h0
`define BCP_START_LVL    1'h1
`define BCP_ZERO_LVL     1'h0
`define BCP_WARN_LVL     1'h1
`define BCP_ERR_NOBIT    1'h1
`define BCP_CORE_CLK_NS  25
`define BCP_CORE_KHZ     40000
`define BCP_TIMEOUT_NS   25000
`define BCP_TIMEOUT_CYC  ((`BCP_TIMEOUT_NS + `BCP_CORE_CLK_NS - 1) / `BCP_CORE_CLK_NS)
`define BCP_LINK_KHZ_DEF 1000
`define BCP_LINK_KHZ_MIN 100
`define BCP_LINK_KHZ_MAX 5000
`define BCP_FLUSH_PULSES 2

`endif

// >>> rtl/bcp_link_if.sv
// Wire pairs between motion controller and encoder.
// The bench joins both ends through one instance of this interface.
`timescale 1ns/1ps
`default_nettype none

interface bcp_link_if;
    logic linkClk;   // Clock pair; receive line of the encoder in service mode
    logic dataBit;   // Frame driver level
    logic dataOe;    // Frame driver enable
    logic dataIdle;  // Level held when the frame driver is off
    logic data;      // Resolved data pair

    assign data = dataOe ? dataBit : dataIdle;

    modport slave  (input linkClk, output dataBit, output dataOe, output dataIdle);
    modport master (output linkClk, input data);
endinterface

`default_nettype wire

// >>> rtl/bcp_master.sv
// Motion controller end of the absolute position link.
// Makes the link clock from core_clk by a divider; samples the data pair
// through two flip-flops.
`timescale 1ns/1ps
`default_nettype none
`include "bcp_defs.svh"

module bcp_master
    import bcp_pkg::*;
#(
    parameter int RES         = `BCP_RES_DEF,
    parameter int LINK_KHZ    = `BCP_LINK_KHZ_DEF,
    parameter int TIMEOUT_CYC = `BCP_TIMEOUT_CYC
) (
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    bcp_link_if.master          link,
    input  wire logic           reqStart,
    input  wire logic           svcMode,
    input  wire logic           svcTxd,
    output logic                linkReady_r,
    output logic                done_r,
    output logic [RES-1:0]      position_r,
    output logic                errFlag_r,
    output logic                warnFlag_r,
    output logic                crcOk_r,
    output logic                frameOk_r,
    output logic                svcRxd_r
);

    // Slowest allowed rate keeps HALF within range; faster than 5 MHz is clamped to 5 MHz
    localparam int KHZ     = (LINK_KHZ > `BCP_LINK_KHZ_MAX) ? `BCP_LINK_KHZ_MAX :
                             (LINK_KHZ < `BCP_LINK_KHZ_MIN) ? `BCP_LINK_KHZ_MIN : LINK_KHZ;
    localparam int HALF    = `BCP_CORE_KHZ / (2 * KHZ);
    localparam int HW      = $clog2(HALF + 1);
    localparam int N       = RES + `BCP_ACK_OFS + 1;
    localparam int CW      = $clog2(TIMEOUT_CYC + 1);
    localparam int E_FIRST = N - (RES + `BCP_POS_LSB - 1);
    localparam int E_LAST  = N - `BCP_WARN_POS;

    bcp_mstate_t   mState_r;
    logic [HW-1:0] halfCnt_r;
    logic [5:0]    edgeCnt_r;
    logic [CW-1:0] tCnt_r;
    logic [N-1:0]  rxSh_r;
    logic [5:0]    crcRx_r;
    logic          clkOut_r;
    logic          dataS1;
    logic          dataS2;
    logic          tick;
    logic          running;

    assign link.linkClk = clkOut_r;
    assign tick         = (halfCnt_r == HW'(HALF - 1));
    assign running      = (mState_r == BCP_MS_FLUSH) || (mState_r == BCP_MS_LOW) ||
                          (mState_r == BCP_MS_HIGH);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dataS1 <= 1'h0;
            dataS2 <= 1'h0;
        end else begin
            dataS1 <= link.data;
            dataS2 <= dataS1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || !running || tick) begin
            halfCnt_r <= '0;
        end else begin
            halfCnt_r <= halfCnt_r + HW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mState_r    <= BCP_MS_FLUSH;
            clkOut_r    <= 1'h1;
            edgeCnt_r   <= 6'h00;
            tCnt_r      <= '0;
            rxSh_r      <= '0;
            crcRx_r     <= 6'h00;
            linkReady_r <= 1'h0;
            done_r      <= 1'h0;
            position_r  <= '0;
            errFlag_r   <= 1'h0;
            warnFlag_r  <= 1'h0;
            crcOk_r     <= 1'h0;
            frameOk_r   <= 1'h0;
            svcRxd_r    <= 1'h1;
        end else begin
            done_r <= 1'h0;
            unique case (mState_r)
                BCP_MS_FLUSH: begin
                    // Pulses that let the encoder's link side leave reset
                    if (tick) begin
                        clkOut_r <= ~clkOut_r;
                        if (!clkOut_r) begin
                            edgeCnt_r <= edgeCnt_r + 6'h01;
                            if (edgeCnt_r == 6'(`BCP_FLUSH_PULSES - 1)) begin
                                tCnt_r   <= '0;
                                mState_r <= BCP_MS_GAP;
                            end
                        end
                    end
                end
                BCP_MS_GAP: begin
                    clkOut_r <= 1'h1;
                    if (tCnt_r != CW'(TIMEOUT_CYC - 1)) begin
                        tCnt_r <= tCnt_r + CW'(1);
                    end else if (dataS2) begin
                        linkReady_r <= 1'h1;
                        mState_r    <= BCP_MS_IDLE;
                    end
                end
                BCP_MS_IDLE: begin
                    if (svcMode) begin
                        linkReady_r <= 1'h0;
                        mState_r    <= BCP_MS_SVC;
                    end else if (reqStart) begin
                        linkReady_r <= 1'h0;
                        clkOut_r    <= 1'h0;
                        edgeCnt_r   <= 6'h00;
                        crcRx_r     <= 6'h00;
                        mState_r    <= BCP_MS_LOW;
                    end
                end
                BCP_MS_LOW: begin
                    if (tick) begin
                        clkOut_r  <= 1'h1;
                        edgeCnt_r <= edgeCnt_r + 6'h01;
                        if (edgeCnt_r != 6'h00) begin
                            rxSh_r <= {rxSh_r[N-2:0], dataS2};
                            if (edgeCnt_r >= 6'(E_FIRST) && edgeCnt_r <= 6'(E_LAST)) begin
                                crcRx_r <= bcpCrcStep(crcRx_r, dataS2);
                            end
                        end
                        mState_r <= (edgeCnt_r == 6'(N)) ? BCP_MS_DONE : BCP_MS_HIGH;
                    end
                end
                BCP_MS_HIGH: begin
                    if (tick) begin
                        clkOut_r <= 1'h0;
                        mState_r <= BCP_MS_LOW;
                    end
                end
                BCP_MS_DONE: begin
                    position_r <= rxSh_r[RES+`BCP_POS_LSB-1:`BCP_POS_LSB];
                    errFlag_r  <= rxSh_r[`BCP_ERR_POS];
                    warnFlag_r <= rxSh_r[`BCP_WARN_POS];
                    crcOk_r    <= (~rxSh_r[`BCP_CRC_W-1:0] == crcRx_r);
                    frameOk_r  <= (rxSh_r[N-1] == `BCP_ACK_LVL) &&
                                  (rxSh_r[N-2] == `BCP_START_LVL) &&
                                  (rxSh_r[N-3] == `BCP_ZERO_LVL);
                    done_r     <= 1'h1;
                    tCnt_r     <= '0;
                    mState_r   <= BCP_MS_GAP;
                end
                BCP_MS_SVC: begin
                    clkOut_r <= svcTxd;
                    svcRxd_r <= dataS2;
                    if (!svcMode) begin
                        // Fresh pulses let the encoder's link side leave service mode
                        edgeCnt_r <= 6'h00;
                        mState_r  <= BCP_MS_FLUSH;
                    end
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> rtl/bcp_pkg.sv
// Types and the shared checksum step of the position link.
// Assumes bcp_defs.svh is on the include path.
`include "bcp_defs.svh"

package bcp_pkg;

    typedef enum logic [1:0] {BCP_LS_IDLE, BCP_LS_SEND, BCP_LS_TAIL} bcp_lstate_t;

    typedef enum logic [1:0] {BCP_CS_TOUT, BCP_CS_READY, BCP_CS_BUSY} bcp_cstate_t;

    typedef enum logic [2:0] {
        BCP_MS_FLUSH, BCP_MS_GAP, BCP_MS_IDLE, BCP_MS_LOW, BCP_MS_HIGH, BCP_MS_DONE, BCP_MS_SVC
    } bcp_mstate_t;

    // One serial step of the x^6 + x + 1 checksum, zero seed
    function automatic logic [5:0] bcpCrcStep(input logic [5:0] crc, input logic din);
        logic fb;
        fb = din ^ crc[5];
        return {crc[4:0], 1'h0} ^ (fb ? `BCP_CRC_POLY : 6'h00);
    endfunction

endpackage

// >>> rtl/bcp_slave.sv
// Encoder end of the absolute position link.
// Frame logic runs on the master's clock pair; timeout and service logic on core_clk.
// Assumes the master honours the gap between frames and gives two flush pulses
// after reset.
`timescale 1ns/1ps
`default_nettype none
`include "bcp_defs.svh"

module bcp_slave
    import bcp_pkg::*;
#(
    parameter int RES         = `BCP_RES_DEF,
    parameter bit HAS_BIT     = 1'h1,
    parameter int TIMEOUT_CYC = `BCP_TIMEOUT_CYC
) (
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    bcp_link_if.slave           link,
    input  wire logic [RES-1:0] position,
    input  wire logic           bitOk,
    input  wire logic           svcMode,
    input  wire logic           svcTxd,
    output logic                svcRxd_r,
    output logic                linkReady_r,
    output logic                frameBusy_r
);

    localparam int         FW        = RES + 2;
    localparam logic [4:0] IDX_ACK   = 5'(RES + `BCP_ACK_OFS);
    localparam logic [4:0] IDX_START = 5'(RES + `BCP_START_OFS);
    localparam logic [4:0] IDX_ZERO  = 5'(RES + `BCP_ZERO_OFS);
    localparam logic [4:0] IDX_CTOP  = 5'(`BCP_CRC_W - 1);
    localparam int         CW        = $clog2(TIMEOUT_CYC + 1);

    // Link domain
    logic             rstL1;
    logic             rstL2;
    logic             svcL1;
    logic             svcL2;
    bcp_lstate_t      lState_r;
    logic [4:0]       bitIdx_r;
    logic [FW-1:0]    fieldSh_r;
    logic [5:0]       crcTx_r;
    logic             txBit_r;
    logic             txOe_r;

    // Core domain
    logic             oeC1;
    logic             oeC2;
    logic             svcC1;
    logic             svcC2;
    logic             rxC1;
    logic             rxC2;
    bcp_cstate_t      cState_r;
    logic [CW-1:0]    tCnt_r;
    logic             idleLvl_r;
    logic [RES-1:0]   posHold_r;
    logic             errHold_r;

    assign link.dataBit  = txBit_r;
    assign link.dataOe   = txOe_r;
    assign link.dataIdle = idleLvl_r;

    // The link clock stands still between frames, so its reset must assert
    // without an edge; release still waits for two link edges.
    always_ff @(posedge link.linkClk or posedge sys_rst) begin
        if (sys_rst) begin
            rstL1 <= 1'h1;
            rstL2 <= 1'h1;
        end else begin
            rstL1 <= 1'h0;
            rstL2 <= rstL1;
        end
    end

    // Service mode stops the frame logic at once: the receive line may give an
    // edge before a plain two-stage sync would see the mode. Leaving it still
    // takes two link edges, which the master supplies as flush pulses.
    always_ff @(posedge link.linkClk or posedge rstL2 or posedge svcC2) begin
        if (rstL2) begin
            svcL1 <= 1'h0;
            svcL2 <= 1'h0;
        end else if (svcC2) begin
            svcL1 <= 1'h1;
            svcL2 <= 1'h1;
        end else begin
            svcL1 <= 1'h0;
            svcL2 <= svcL1;
        end
    end

    // Frame shifter. posHold_r and errHold_r are only refreshed during the
    // gap, so they are stable when the first edge of a frame samples them.
    always_ff @(posedge link.linkClk or posedge rstL2) begin
        if (rstL2) begin
            lState_r  <= BCP_LS_IDLE;
            bitIdx_r  <= 5'h00;
            fieldSh_r <= '0;
            crcTx_r   <= 6'h00;
            txBit_r   <= 1'h0;
            txOe_r    <= 1'h0;
        end else begin
            unique case (lState_r)
                BCP_LS_IDLE: begin
                    if (!svcL2) begin
                        txBit_r   <= `BCP_ACK_LVL;
                        txOe_r    <= 1'h1;
                        fieldSh_r <= {posHold_r, errHold_r, `BCP_WARN_LVL};
                        crcTx_r   <= 6'h00;
                        bitIdx_r  <= IDX_ACK - 5'h01;
                        lState_r  <= BCP_LS_SEND;
                    end
                end
                BCP_LS_SEND: begin
                    if (svcL2) begin
                        txOe_r   <= 1'h0;
                        lState_r <= BCP_LS_IDLE;
                    end else begin
                        if (bitIdx_r == IDX_START) begin
                            txBit_r <= `BCP_START_LVL;
                        end else if (bitIdx_r == IDX_ZERO) begin
                            txBit_r <= `BCP_ZERO_LVL;
                        end else if (bitIdx_r > IDX_CTOP) begin
                            txBit_r   <= fieldSh_r[FW-1];
                            fieldSh_r <= {fieldSh_r[FW-2:0], 1'h0};
                            crcTx_r   <= bcpCrcStep(crcTx_r, fieldSh_r[FW-1]);
                        end else begin
                            txBit_r <= ~crcTx_r[5];
                            crcTx_r <= {crcTx_r[4:0], 1'h0};
                        end
                        bitIdx_r <= bitIdx_r - 5'h01;
                        if (bitIdx_r == 5'h00) begin
                            lState_r <= BCP_LS_TAIL;
                        end
                    end
                end
                BCP_LS_TAIL: begin
                    // Driver off; the core side holds the line low through the gap
                    txBit_r  <= 1'h0;
                    txOe_r   <= 1'h0;
                    lState_r <= BCP_LS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            oeC1  <= 1'h0;
            oeC2  <= 1'h0;
            svcC1 <= 1'h0;
            svcC2 <= 1'h0;
            rxC1  <= 1'h1;
            rxC2  <= 1'h1;
        end else begin
            oeC1  <= txOe_r;
            oeC2  <= oeC1;
            svcC1 <= svcMode;
            svcC2 <= svcC1;
            rxC1 <= link.linkClk;
            rxC2 <= rxC1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            svcRxd_r <= 1'h1;
        end else begin
            svcRxd_r <= rxC2;
        end
    end

    // Gap timing and idle level of the data pair
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cState_r    <= BCP_CS_TOUT;
            tCnt_r      <= '0;
            idleLvl_r   <= 1'h0;
            posHold_r   <= '0;
            errHold_r   <= `BCP_ERR_NOBIT;
            linkReady_r <= 1'h0;
            frameBusy_r <= 1'h0;
        end else if (svcC2) begin
            // Data pair becomes the transmit line; the gap restarts on exit
            idleLvl_r   <= svcTxd;
            cState_r    <= BCP_CS_TOUT;
            tCnt_r      <= '0;
            linkReady_r <= 1'h0;
            frameBusy_r <= 1'h0;
        end else begin
            unique case (cState_r)
                BCP_CS_TOUT: begin
                    idleLvl_r <= 1'h0;
                    posHold_r <= position;
                    errHold_r <= HAS_BIT ? bitOk : `BCP_ERR_NOBIT;
                    if (oeC2) begin
                        cState_r    <= BCP_CS_BUSY;
                        frameBusy_r <= 1'h1;
                    end else if (tCnt_r == CW'(TIMEOUT_CYC - 1)) begin
                        idleLvl_r   <= 1'h1;
                        linkReady_r <= 1'h1;
                        cState_r    <= BCP_CS_READY;
                    end else begin
                        tCnt_r <= tCnt_r + CW'(1);
                    end
                end
                BCP_CS_READY: begin
                    if (oeC2) begin
                        idleLvl_r   <= 1'h0;
                        linkReady_r <= 1'h0;
                        frameBusy_r <= 1'h1;
                        cState_r    <= BCP_CS_BUSY;
                    end
                end
                BCP_CS_BUSY: begin
                    idleLvl_r <= 1'h0;
                    if (!oeC2) begin
                        // Gap counts from the end of the frame as seen here
                        tCnt_r      <= '0;
                        frameBusy_r <= 1'h0;
                        cState_r    <= BCP_CS_TOUT;
                    end
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> verification/bcp_link_checker.sv
// Assertions on the position link wires between the two ends.
// Instantiated by the bench beside the link interface; sees plain signals only.
`timescale 1ns/1ps
`default_nettype none
`include "bcp_defs.svh"

module bcp_link_checker #(
    parameter int RES         = `BCP_RES_DEF,
    parameter int TIMEOUT_CYC = `BCP_TIMEOUT_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic linkClk,
    input wire logic dataBit,
    input wire logic dataOe,
    input wire logic dataIdle,
    input wire logic data
);
    localparam int N = RES + `BCP_ACK_OFS + 1;
    int         bitCnt_r;
    int         gapCnt_r;
    int         lowCnt_r;
    logic [5:0] crc_r;
    logic       oePrev_r;
    logic       armed_r;

    // Bit index of the sample is N-1-bitCnt_r while the driver is on
    always_ff @(posedge linkClk or posedge sys_rst) begin
        if (sys_rst) bitCnt_r <= 0;
        else if (!dataOe) bitCnt_r <= 0;
        else bitCnt_r <= bitCnt_r + 1;
    end
    always_ff @(posedge linkClk or posedge sys_rst) begin
        if (sys_rst) crc_r <= 6'h00;
        else if (!dataOe) crc_r <= 6'h00;
        else if (bitCnt_r >= 3 && bitCnt_r <= N - 7)
            crc_r <= {crc_r[4:0], 1'h0} ^ ((dataBit ^ crc_r[5]) ? `BCP_CRC_POLY : 6'h00);
    end
    // Gap is timed from the raw driver release, earlier than the slave sees it
    always_ff @(posedge core_clk) begin
        oePrev_r <= dataOe;
        if (sys_rst) armed_r <= 1'h0;
        else if (oePrev_r && !dataOe) armed_r <= 1'h1;
        else if (data) armed_r <= 1'h0;
    end
    always_ff @(posedge core_clk) begin
        if (oePrev_r && !dataOe) gapCnt_r <= 0;
        else gapCnt_r <= gapCnt_r + 1;
    end
    always_ff @(posedge core_clk) begin
        if (linkClk) lowCnt_r <= 0;
        else lowCnt_r <= lowCnt_r + 1;
    end

    chk_ack_low: assert property (
        @(posedge linkClk) disable iff (sys_rst) $rose(dataOe) |-> !dataBit)
        else $error("ack slot not low");
    chk_start_zero: assert property (
        @(posedge linkClk) disable iff (sys_rst) $rose(dataOe) |=> dataBit ##1 !dataBit)
        else $error("start or zero bit wrong");
    chk_frame_len: assert property (
        @(posedge linkClk) disable iff (sys_rst) dataOe ##1 !dataOe |-> bitCnt_r == N)
        else $error("frame length wrong");
    chk_warn_high: assert property (
        @(posedge linkClk) disable iff (sys_rst) dataOe && bitCnt_r == N - 7 |-> dataBit)
        else $error("warning bit not high");
    chk_crc_sent: assert property (
        @(posedge linkClk) disable iff (sys_rst)
        dataOe && bitCnt_r >= N - 6 |-> dataBit == !crc_r[N - 1 - bitCnt_r])
        else $error("checksum bit wrong");
    chk_tail_low: assert property (
        @(posedge core_clk) disable iff (sys_rst) $fell(dataOe) |-> (!data && !dataIdle)[*8])
        else $error("data not low after frame");
    chk_gap_min: assert property (
        @(posedge core_clk) disable iff (sys_rst) armed_r && data |-> gapCnt_r >= TIMEOUT_CYC)
        else $error("data ready before timeout");
    chk_gap_max: assert property (
        @(posedge core_clk) disable iff (sys_rst) armed_r |-> gapCnt_r <= TIMEOUT_CYC + 16)
        else $error("data not ready after timeout");
    chk_clk_idle: assert property (
        @(posedge core_clk) disable iff (sys_rst) armed_r |-> linkClk)
        else $error("clock moved inside gap");
    chk_clk_rate: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        $rose(linkClk) |-> lowCnt_r >= 4 && lowCnt_r <= 200)
        else $error("clock low phase out of range");
endmodule

`default_nettype wire

// >>> verification/encoder_biss_c_position_slave_test.sv
// Bench joining encoder end and controller end through one link interface.
// Frames are requested at the controller and checked on the wire and at its results.
`timescale 1ns/1ps
`default_nettype none
`include "bcp_defs.svh"
`define CHECK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module encoder_biss_c_position_slave_test;
    import bcp_pkg::*;
    localparam int RES = 20;
    localparam int TO  = 40;
    localparam int N   = RES + `BCP_ACK_OFS + 1;
    logic           core_clk   = 1'h0;
    logic           sys_rst    = 1'h1;
    logic           reqStart   = 1'h0;
    logic           svcMode    = 1'h0;
    logic           mSvcTxd    = 1'h1;
    logic           sSvcTxd    = 1'h1;
    logic           bitOk      = 1'h1;
    logic [RES-1:0] position   = 20'h0_0000;
    logic           sSvcRxd;
    logic           sLinkReady;
    logic           sBusy;
    logic           mLinkReady;
    logic           mDone;
    logic [RES-1:0] mPos;
    logic           mErr;
    logic           mWarn;
    logic           mCrcOk;
    logic           mFrameOk;
    logic           mSvcRxd;
    int             n_mismatch = 0;
    int             n_tests    = 0;

    always #12.5 core_clk = ~core_clk;

    bcp_link_if i_bcp_link_if ();
    bcp_slave #(.RES(RES), .HAS_BIT(1'h1), .TIMEOUT_CYC(TO)) i_bcp_slave (
        .core_clk(core_clk), .sys_rst(sys_rst), .link(i_bcp_link_if.slave),
        .position(position), .bitOk(bitOk), .svcMode(svcMode), .svcTxd(sSvcTxd),
        .svcRxd_r(sSvcRxd), .linkReady_r(sLinkReady), .frameBusy_r(sBusy));
    bcp_master #(.RES(RES), .LINK_KHZ(1000), .TIMEOUT_CYC(TO)) i_bcp_master (
        .core_clk(core_clk), .sys_rst(sys_rst), .link(i_bcp_link_if.master),
        .reqStart(reqStart), .svcMode(svcMode), .svcTxd(mSvcTxd),
        .linkReady_r(mLinkReady), .done_r(mDone), .position_r(mPos), .errFlag_r(mErr),
        .warnFlag_r(mWarn), .crcOk_r(mCrcOk), .frameOk_r(mFrameOk), .svcRxd_r(mSvcRxd));
    bcp_link_checker #(.RES(RES), .TIMEOUT_CYC(TO)) i_bcp_link_checker (
        .core_clk(core_clk), .sys_rst(sys_rst), .linkClk(i_bcp_link_if.linkClk),
        .dataBit(i_bcp_link_if.dataBit), .dataOe(i_bcp_link_if.dataOe),
        .dataIdle(i_bcp_link_if.dataIdle), .data(i_bcp_link_if.data));

    task automatic results();
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Reads after this see the values that stood before the edge
    task automatic tick();
        @(posedge core_clk);
    endtask

    task automatic timedOut(input int n, input int lim);
        if (n >= lim) begin
            n_mismatch++;
            $display("ERROR wait ran out after %0d cycles", n);
            results();
        end
    endtask

    // Serial checksum, seed zero, over position, error and warning
    function automatic logic [5:0] crc6(input logic [RES+1:0] v);
        logic [5:0] c;
        c = 6'h00;
        for (int i = RES + 1; i >= 0; i--) begin
            c = {c[4:0], 1'h0} ^ ((v[i] ^ c[5]) ? 6'h03 : 6'h00);
        end
        return c;
    endfunction

    // Request held until TO-5 cycles into the gap: the controller must not start early
    // The encoder samples position only during the gap, so the next frame's
    // value is presented right after this frame ends.
    task automatic frame(input logic [RES-1:0] p, input logic ok, input logic [RES-1:0] pNext,
                         input logic okNext);
        logic [N-1:0] ex;
        logic         prev;
        int           k;
        int           n;
        ex = {3'h2, p, ok, 1'h1, ~crc6({p, ok, 1'h1})};
        n = 0;
        while (mLinkReady !== 1'h1 && n < 4000) begin
            tick();
            n++;
        end
        timedOut(n, 4000);
        `CHECK("slave ready", 1'h1, sLinkReady)
        reqStart <= 1'h1;
        k = 0;
        n = 0;
        prev = 1'h1;
        while (mDone !== 1'h1 && n < 4000) begin
            tick();
            n++;
            if (prev === 1'h1 && i_bcp_link_if.linkClk === 1'h0) begin
                if (k > 0) `CHECK("frame bit", ex[N-k], i_bcp_link_if.data)
                if (k == 1) `CHECK("slave busy", 1'h1, sBusy)
                k++;
            end
            prev = i_bcp_link_if.linkClk;
        end
        timedOut(n, 4000);
        position <= pNext;
        bitOk <= okNext;
        `CHECK("clock falls", N + 1, k)
        `CHECK("position", p, mPos)
        `CHECK("error flag", ok, mErr)
        `CHECK("warning flag", 1'h1, mWarn)
        `CHECK("checksum ok", 1'h1, mCrcOk)
        `CHECK("framing ok", 1'h1, mFrameOk)
        tick();
        `CHECK("tail level", 1'h0, i_bcp_link_if.data)
        n = 0;
        while (i_bcp_link_if.data !== 1'h1 && n < 4000) begin
            tick();
            n++;
            if (n == TO - 5) reqStart <= 1'h0;
            `CHECK("clock held", 1'h1, i_bcp_link_if.linkClk)
        end
        timedOut(n, 4000);
        `CHECK("gap length", 1'h1, n >= TO - 2)
        `CHECK("slave idle", 1'h0, sBusy)
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'h0;
        frame(20'h0_0000, 1'h1, 20'hF_FFFF, 1'h1);
        frame(20'hF_FFFF, 1'h1, 20'hA_5C3E, 1'h0);
        frame(20'hA_5C3E, 1'h0, 20'h5_A3C1, 1'h1);
        svcMode <= 1'h1;
        repeat (8) tick();
        for (int v = 0; v < 2; v++) begin
            mSvcTxd <= v[0];
            sSvcTxd <= ~v[0];
            repeat (8) tick();
            `CHECK("receive line", v[0], i_bcp_link_if.linkClk)
            `CHECK("slave receive", v[0], sSvcRxd)
            `CHECK("transmit line", ~v[0], i_bcp_link_if.data)
            `CHECK("master receive", ~v[0], mSvcRxd)
        end
        sSvcTxd <= 1'h1;
        tick();
        svcMode <= 1'h0;
        frame(20'h5_A3C1, 1'h1, 20'h5_A3C1, 1'h1);
        results();
    end
endmodule

`default_nettype wire
